// ---- core/iav_map.svh ----
// Address, offset, reset and vector constants for the interrupt autovector block.
`ifndef IAV_MAP_SVH
`define IAV_MAP_SVH

// Code-space locations of the two interrupt entries.
`define IAV_USB_ENTRY 16'h0043
`define IAV_USB_PAGE 16'h0044
`define IAV_USB_VECLOC 16'h0045
`define IAV_FIFO_ENTRY 16'h0053
`define IAV_FIFO_PAGE 16'h0054
`define IAV_FIFO_VECLOC 16'h0055

// Source counts and vector coding.
`define IAV_USB_SLOTS 32
`define IAV_FIFO_SRCS 14
`define IAV_USB_RSVD 32'h0c02_00a0
`define IAV_USB_BASE 8'h00
`define IAV_FIFO_BASE 8'h80

// Register byte offsets on the APB.
`define IAV_OFS_SETUP 8'h00
`define IAV_OFS_USB_IE 8'h04
`define IAV_OFS_USB_PEND 8'h08
`define IAV_OFS_FIFO_IE 8'h0c
`define IAV_OFS_FIFO_PEND 8'h10
`define IAV_OFS_VECTORS 8'h14

// Reset values.
`define IAV_RST_SETUP 2'h0
`define IAV_RST_USB 32'h0000_0000
`define IAV_RST_FIFO 14'h0000
`define IAV_RST_BYTE 8'h00
`define IAV_RST_ADDR 16'h0000

`endif

// ---- core/iav_pkg.sv ----
// Types shared by the interrupt autovector block.
package iav_pkg;
    // Entry sequencer states, Gray coded along idle, push, jump.
    typedef enum logic [1:0]
    {
        IAV_IDLE = 2'b00,
        IAV_PUSH = 2'b01,
        IAV_JUMP = 2'b11
    } iav_state_t;

    // One vector byte.
    typedef logic [7:0] iav_vec_t;
endpackage : iav_pkg

// ---- core/iav_enc_if.sv ----
// Carrier between the autovector core and its priority encoder.
`timescale 1ns/1ps
`default_nettype none
`include "iav_map.svh"

interface iav_enc_if;
    logic [`IAV_USB_SLOTS-1:0] usbReq; // Pending and enabled USB sources.
    logic [`IAV_FIFO_SRCS-1:0] fifoReq; // Pending and enabled FIFO sources.
    iav_pkg::iav_vec_t usbVec; // Winning USB vector.
    iav_pkg::iav_vec_t fifoVec; // Winning FIFO vector.
    logic usbAny; // Some USB source requests.
    logic fifoAny; // Some FIFO source requests.

    modport core (output usbReq, output fifoReq, input usbVec, input fifoVec, input usbAny, input fifoAny);
    modport enc (input usbReq, input fifoReq, output usbVec, output fifoVec, output usbAny, output fifoAny);
endinterface : iav_enc_if

`default_nettype wire

// ---- core/iav_vec_enc.sv ----
// Fixed-priority encoders producing the USB and FIFO vector bytes.
`timescale 1ns/1ps
`default_nettype none
`include "iav_map.svh"

module iav_vec_enc
(
    iav_enc_if.enc bus // Request vectors in, vector bytes out.
);
    import iav_pkg::*;

    // Returns the index of the lowest set bit; bit zero is the highest priority.
    function automatic logic [4:0] first_set(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'd0;
        for (int i = 31; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : first_set

    logic [4:0] usbIdx; // Winning USB slot.
    logic [4:0] fifoIdx; // Winning FIFO slot.

    // Vector equals four times the slot, on top of each line's base.
    always_comb
    begin
        usbIdx = first_set(bus.usbReq);
        fifoIdx = first_set({18'h0, bus.fifoReq});
        bus.usbVec = `IAV_USB_BASE + {1'b0, usbIdx, 2'b00};
        bus.fifoVec = `IAV_FIFO_BASE + {1'b0, fifoIdx, 2'b00};
        bus.usbAny = |bus.usbReq;
        bus.fifoAny = |bus.fifoReq;
    end
endmodule : iav_vec_enc

`default_nettype wire

// ---- core/iav_autovector.sv ----
// Two-line interrupt autovector controller with APB registers and code-fetch substitution.
//
// Operation
// - Merge USB and FIFO sources onto two lines.
// - USB entry: push PC, fetch 0x0043.
// - Substitute USB vector at 0x0045 when enabled.
// - FIFO entry: push PC, fetch 0x0053.
// - Substitute FIFO vector at 0x0055 when enabled.
// - USB vector is four times slot index.
// - Handshake acknowledged uses vector 18.
// - Endpoint 0/1 events use vectors 20-2C.
// - Large endpoints 2,4,6,8 use 30-3C.
// - Bulk IN NAK uses vector 40.
// - Ping NAK sources use vectors 48-5C.
// - Bus error limit uses vector 60.
// - Iso PID errors use vectors 70-7C.
// - Programmable flags use FIFO vectors 80-8C.
// - Empty flags use FIFO vectors 90-9C.
// - Full flags use FIFO vectors A0-AC.
// - Waveform done B0, waveform event B4.
`timescale 1ns/1ps
`default_nettype none
`include "iav_map.svh"

module iav_autovector
(
    input wire logic mclk, // Core clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped address.
    input wire logic [`IAV_USB_SLOTS-1:0] usbSrc, // USB event pulses, slot order.
    input wire logic [`IAV_FIFO_SRCS-1:0] fifoSrc, // FIFO and waveform event pulses.
    output logic usb_irq_line, // Shared USB interrupt request.
    output logic fifo_irq_line, // Shared FIFO interrupt request.
    input wire logic [1:0] irqTake, // Core takes USB (bit 0) or FIFO (bit 1).
    output logic pushPc, // Core pushes its program counter.
    output logic entryValid, // Entry address is valid for the jump.
    output logic [15:0] entryAddr, // Entry address to fetch from.
    input wire logic codeFetch, // Code byte fetch strobe.
    input wire logic [15:0] codeAddr, // Fetch address.
    input wire logic [7:0] memByte, // Byte read from code memory.
    output logic fetchValid, // Fetched byte is valid.
    output logic [7:0] fetchByte // Fetched byte, possibly substituted.
);
    import iav_pkg::*;

    // ----------------------------------------------------------------
    // State and wiring
    // ----------------------------------------------------------------
    iav_enc_if encBus(); // Link to the priority encoder.

    logic [1:0] setup_ff; // Bit 0 USB autovector, bit 1 FIFO autovector.
    logic [`IAV_USB_SLOTS-1:0] usbIe_ff; // USB source enables.
    logic [`IAV_USB_SLOTS-1:0] usbPend_ff; // USB sticky pending flags.
    logic [`IAV_FIFO_SRCS-1:0] fifoIe_ff; // FIFO source enables.
    logic [`IAV_FIFO_SRCS-1:0] fifoPend_ff; // FIFO sticky pending flags.
    logic [31:0] prdata_ff; // Captured read data.
    logic perr_ff; // Captured unmapped-address flag.
    iav_state_t state_ff; // Entry sequencer state.
    logic [15:0] entryAddr_ff; // Latched entry address.
    logic [7:0] fetchByte_ff; // Returned code byte.
    logic fetchValid_ff; // Returned byte strobe.

    logic usb_autovector_enable; // USB autovector switch.
    logic fifo_autovector_enable; // FIFO autovector switch.
    iav_vec_t usb_vector_byte; // Current USB vector.
    iav_vec_t fifo_vector_byte; // Current FIFO vector.
    logic setupPhase; // APB setup cycle.
    logic wrStrobe; // APB write completes this edge.
    logic mapped; // Address hits a register.

    assign usb_autovector_enable = setup_ff[0];
    assign fifo_autovector_enable = setup_ff[1];
    assign usb_vector_byte = encBus.usbVec;
    assign fifo_vector_byte = encBus.fifoVec;

    // ----------------------------------------------------------------
    // Priority encoding
    // ----------------------------------------------------------------
    // Only pending and enabled sources compete for the vector.
    assign encBus.usbReq = usbPend_ff & usbIe_ff;
    assign encBus.fifoReq = fifoPend_ff & fifoIe_ff;

    iav_vec_enc u_enc
    (
        .bus(encBus.enc)
    );

    // Each line is the OR of its enabled pending sources.
    assign usb_irq_line = encBus.usbAny;
    assign fifo_irq_line = encBus.fifoAny;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign setupPhase = psel && !penable;
    assign wrStrobe = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_ff;
    assign pslverr = psel && penable && perr_ff;

    // Address decode for the error flag; the read capture decodes paddr on its own.
    always_comb
    begin
        case (paddr)
            `IAV_OFS_SETUP, `IAV_OFS_USB_IE, `IAV_OFS_USB_PEND,
            `IAV_OFS_FIFO_IE, `IAV_OFS_FIFO_PEND, `IAV_OFS_VECTORS:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle so it is stable in the access cycle.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_ff <= 32'h0000_0000;
            perr_ff <= 1'b0;
        end
        else if (setupPhase)
        begin
            perr_ff <= !mapped;
            case (paddr)
                `IAV_OFS_SETUP: prdata_ff <= {30'h0, setup_ff};
                `IAV_OFS_USB_IE: prdata_ff <= usbIe_ff;
                `IAV_OFS_USB_PEND: prdata_ff <= usbPend_ff;
                `IAV_OFS_FIFO_IE: prdata_ff <= {18'h0, fifoIe_ff};
                `IAV_OFS_FIFO_PEND: prdata_ff <= {18'h0, fifoPend_ff};
                `IAV_OFS_VECTORS: prdata_ff <= {16'h0, fifo_vector_byte, usb_vector_byte};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Setup register holds the two autovector switches.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            setup_ff <= `IAV_RST_SETUP;
        end
        else if (wrStrobe && paddr == `IAV_OFS_SETUP)
        begin
            setup_ff <= pwdata[1:0];
        end
    end

    // Enable registers; reserved USB slots can never be enabled.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            usbIe_ff <= `IAV_RST_USB;
            fifoIe_ff <= `IAV_RST_FIFO;
        end
        else if (wrStrobe)
        begin
            if (paddr == `IAV_OFS_USB_IE)
            begin
                usbIe_ff <= pwdata & ~`IAV_USB_RSVD;
            end
            if (paddr == `IAV_OFS_FIFO_IE)
            begin
                fifoIe_ff <= pwdata[`IAV_FIFO_SRCS-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pending flags
    // ----------------------------------------------------------------
    // Write one to clear; a new event in the same cycle wins over the clear.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            usbPend_ff <= `IAV_RST_USB;
        end
        else
        begin
            // Slots: 0 setup data, 6 handshake acked, 8..11 EP0/EP1, 12..15 EP2-8.
            // Slot 16 bulk IN NAK, 18..23 ping NAK, 24 error limit, 28..31 iso errors.
            usbPend_ff <= ((wrStrobe && paddr == `IAV_OFS_USB_PEND) ? (usbPend_ff & ~pwdata) : usbPend_ff)
                          | (usbSrc & ~`IAV_USB_RSVD);
        end
    end

    // FIFO flags: 0..3 programmable, 4..7 empty, 8..11 full, 12 done, 13 waveform.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifoPend_ff <= `IAV_RST_FIFO;
        end
        else
        begin
            // Source order fixes the FIFO vectors.
            fifoPend_ff <= ((wrStrobe && paddr == `IAV_OFS_FIFO_PEND)
                           ? (fifoPend_ff & ~pwdata[`IAV_FIFO_SRCS-1:0]) : fifoPend_ff) | fifoSrc;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt entry sequencer
    // ----------------------------------------------------------------
    // On a take the core first pushes its counter, then jumps to the entry.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= IAV_IDLE;
            entryAddr_ff <= `IAV_RST_ADDR;
        end
        else
        begin
            case (state_ff)
                IAV_IDLE:
                begin
                    // USB is the higher line when both are taken together.
                    if (irqTake[0])
                    begin
                        state_ff <= IAV_PUSH;
                        entryAddr_ff <= `IAV_USB_ENTRY;
                    end
                    else if (irqTake[1])
                    begin
                        state_ff <= IAV_PUSH;
                        entryAddr_ff <= `IAV_FIFO_ENTRY;
                    end
                end
                IAV_PUSH:
                    state_ff <= IAV_JUMP;
                IAV_JUMP:
                    state_ff <= IAV_IDLE;
                default:
                    state_ff <= IAV_IDLE;
            endcase
        end
    end

    assign pushPc = (state_ff == IAV_PUSH);
    assign entryValid = (state_ff == IAV_JUMP);
    assign entryAddr = entryAddr_ff;

    // ----------------------------------------------------------------
    // Code fetch substitution
    // ----------------------------------------------------------------
    // Jump opcode and page byte come from memory; only the low target byte is replaced.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fetchByte_ff <= `IAV_RST_BYTE;
            fetchValid_ff <= 1'b0;
        end
        else
        begin
            fetchValid_ff <= codeFetch;
            if (codeFetch)
            begin
                if (usb_autovector_enable && codeAddr == `IAV_USB_VECLOC)
                begin
                    fetchByte_ff <= usb_vector_byte;
                end
                else if (fifo_autovector_enable && codeAddr == `IAV_FIFO_VECLOC)
                begin
                    fetchByte_ff <= fifo_vector_byte;
                end
                else
                begin
                    // Page bytes and disabled lines read straight from memory.
                    fetchByte_ff <= memByte;
                end
            end
        end
    end

    assign fetchByte = fetchByte_ff;
    assign fetchValid = fetchValid_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_usb_line_raise: assert property (usbSrc[0] && usbIe_ff[0] |=> usb_irq_line)
        else $error("USB line not raised by enabled source.");
    a_usb_entry_seq: assert property ((state_ff == IAV_IDLE) && irqTake[0]
        |=> pushPc ##1 (entryValid && entryAddr == `IAV_USB_ENTRY))
        else $error("USB entry sequence wrong.");
    a_usb_vec_subst: assert property (codeFetch && usb_autovector_enable && codeAddr == `IAV_USB_VECLOC
        |=> fetchValid && fetchByte == $past(usb_vector_byte))
        else $error("USB vector byte not substituted.");
    a_fifo_entry_seq: assert property ((state_ff == IAV_IDLE) && irqTake == 2'b10
        |=> pushPc ##1 (entryValid && entryAddr == `IAV_FIFO_ENTRY))
        else $error("FIFO entry sequence wrong.");
    a_fifo_vec_subst: assert property (codeFetch && fifo_autovector_enable && codeAddr == `IAV_FIFO_VECLOC
        |=> fifoValidByte(fetchByte, $past(fifo_vector_byte)))
        else $error("FIFO vector byte not substituted.");
    a_usb_top_vec: assert property (usbPend_ff[0] && usbIe_ff[0] |-> usb_vector_byte == `IAV_USB_BASE)
        else $error("Top USB source lost priority.");
    a_fifo_top_vec: assert property (fifoPend_ff[0] && fifoIe_ff[0]
        |-> fifo_vector_byte == `IAV_FIFO_BASE)
        else $error("Top FIFO source lost priority.");
    a_rsvd_never: assert property ((usbPend_ff & `IAV_USB_RSVD) == `IAV_RST_USB)
        else $error("Reserved USB slot became pending.");
    a_vec_passthru: assert property (codeFetch && !usb_autovector_enable && codeAddr == `IAV_USB_VECLOC
        |=> fetchByte == $past(memByte))
        else $error("Disabled autovector altered the byte.");

    // Compares a returned byte with the expected vector.
    function automatic logic fifoValidByte(input logic [7:0] got, input logic [7:0] want);
        return got == want;
    endfunction : fifoValidByte
endmodule : iav_autovector

`default_nettype wire

// ---- dv/iav_core_model.sv ----
// Partner model of the processor core that takes interrupts and fetches the vector bytes.
`timescale 1ns/1ps
`default_nettype none

module iav_core_model
(
    input wire logic mclk, // Core clock.
    output logic [1:0] irqTake, // Take request, bit 0 USB, bit 1 FIFO.
    input wire logic pushPc, // Push strobe from the block.
    input wire logic entryValid, // Entry address strobe.
    input wire logic [15:0] entryAddr, // Entry address.
    output logic codeFetch, // Fetch strobe.
    output logic [15:0] codeAddr, // Fetch address.
    output logic [7:0] memByte, // Code memory byte.
    input wire logic fetchValid, // Fetched byte strobe.
    input wire logic [7:0] fetchByte // Fetched byte.
);
    logic [7:0] codeMem [0:255]; // Low page of code memory.

    // ---------------------------------------------------------------
    // Code memory
    // ---------------------------------------------------------------
    // Jump opcode and page bytes are in place before any take.
    initial
    begin
        irqTake = 2'h0;
        codeFetch = 1'b0;
        codeAddr = 16'h0000;
        codeMem = '{default: 8'hff};
        codeMem[8'h43] = 8'h02;
        codeMem[8'h44] = 8'h12;
        codeMem[8'h45] = 8'h77; // Raw byte, seen only when substitution is off.
        codeMem[8'h53] = 8'h02;
        codeMem[8'h54] = 8'h34;
        codeMem[8'h55] = 8'h99; // Raw byte, seen only when substitution is off.
    end

    // Outside a strobed fetch the memory shows the inverted byte, so a stale value never looks right.
    assign memByte = codeFetch ? codeMem[codeAddr[7:0]] : ~codeMem[codeAddr[7:0]];

    // ---------------------------------------------------------------
    // Interrupt entry
    // ---------------------------------------------------------------
    // Takes one line, then fetches opcode, page and vector back to back.
    task automatic serve(input logic [1:0] sel, output logic [15:0] ent, output logic [23:0] got,
                         output logic [2:0] seen);
        @(posedge mclk);
        irqTake <= sel;
        @(posedge mclk);
        irqTake <= 2'h0;
        #1;
        seen = {2'b10, pushPc};
        @(posedge mclk);
        #1;
        seen[1] = entryValid;
        ent = entryAddr;
        @(posedge mclk);
        codeFetch <= 1'b1;
        codeAddr <= ent;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge mclk);
            codeAddr <= ent + 16'(i + 1);
            codeFetch <= (i < 2);
            #1;
            got = {got[15:0], fetchByte};
            seen[2] = seen[2] & fetchValid;
        end
    endtask : serve
endmodule : iav_core_model

`default_nettype wire

// ---- dv/iav_autovector_tb.sv ----
// Self-checking testbench for the interrupt autovector block.
`timescale 1ns/1ps
`default_nettype none
`include "iav_map.svh"

module iav_autovector_tb;
    logic mclk = 1'b0; // Core clock, 50 MHz.
    logic rst_n = 1'b0; // Reset, active low.
    logic psel = 1'b0; // APB select.
    logic penable = 1'b0; // APB access phase.
    logic pwrite = 1'b0; // APB direction.
    logic [7:0] paddr = 8'h00; // APB address.
    logic [31:0] pwdata = 32'h0; // APB write data.
    logic [31:0] prdata; // APB read data.
    logic pready; // APB ready.
    logic pslverr; // APB error.
    logic [31:0] usbSrc = 32'h0; // USB event inputs.
    logic [13:0] fifoSrc = 14'h0; // FIFO event inputs.
    logic usbIrq; // USB line.
    logic fifoIrq; // FIFO line.
    logic [1:0] irqTake; // Take request.
    logic pushPc; // Push strobe.
    logic entryValid; // Entry strobe.
    logic [15:0] entryAddr; // Entry address.
    logic codeFetch; // Fetch strobe.
    logic [15:0] codeAddr; // Fetch address.
    logic [7:0] memByte; // Memory byte.
    logic fetchValid; // Fetch strobe out.
    logic [7:0] fetchByte; // Fetched byte.
    int badCount = 0; // Mismatches seen.
    int testsRun = 0; // Comparisons made.

    iav_autovector dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .usbSrc(usbSrc), .fifoSrc(fifoSrc), .usb_irq_line(usbIrq), .fifo_irq_line(fifoIrq),
        .irqTake(irqTake), .pushPc(pushPc), .entryValid(entryValid), .entryAddr(entryAddr),
        .codeFetch(codeFetch), .codeAddr(codeAddr), .memByte(memByte), .fetchValid(fetchValid),
        .fetchByte(fetchByte));

    iav_core_model core_u (.mclk(mclk), .irqTake(irqTake), .pushPc(pushPc), .entryValid(entryValid),
        .entryAddr(entryAddr), .codeFetch(codeFetch), .codeAddr(codeAddr), .memByte(memByte),
        .fetchValid(fetchValid), .fetchByte(fetchByte));

    // Clock toggles every half period.
    always #10 mclk = ~mclk;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Compares and counts; a difference is printed at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            badCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is seen high, and only the watchdog ends a wait.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // The write lands at this edge, so callers look at the outputs only once it has settled.
        #1;
    endtask : apb

    // Register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask : wr

    // Register read returning the data.
    task automatic rdv(input logic [7:0] a, output logic [31:0] rd);
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
    endtask : rdv

    // Pulses every source of one line for a single cycle.
    task automatic pulse(input bit f);
        @(posedge mclk);
        usbSrc <= f ? 32'h0 : 32'hffff_ffff;
        fifoSrc <= f ? 14'h3fff : 14'h0;
        @(posedge mclk);
        usbSrc <= 32'h0;
        fifoSrc <= 14'h0;
    endtask : pulse

    // Raises all sources of a line, then serves and clears them one by one in priority order.
    task automatic walk(input bit f, input logic [7:0] ie, input logic [7:0] pd, input logic [31:0] mask,
                        input logic [7:0] base, input logic [15:0] entry, input logic [7:0] pg);
        logic [31:0] rd;
        logic [15:0] ent;
        logic [23:0] got;
        logic [2:0] seen;
        wr(ie, 32'hffff_ffff);
        rdv(ie, rd);
        chk(rd, mask);
        pulse(f);
        rdv(pd, rd);
        chk(rd, mask);
        for (int i = 0; i < 32; i++)
        begin
            if (mask[i])
            begin
                rdv(`IAV_OFS_VECTORS, rd);
                chk(f ? rd[15:8] : rd[7:0], base + 8'(4 * i));
                chk(f ? fifoIrq : usbIrq, 1'b1);
                core_u.serve(f ? 2'b10 : 2'b01, ent, got, seen);
                chk(seen, 3'b111);
                chk(ent, entry);
                chk(got, {8'h02, pg, base + 8'(4 * i)});
                wr(pd, 32'h1 << i);
            end
        end
        chk(f ? fifoIrq : usbIrq, 1'b0);
        pulse(f);
        wr(ie, 32'h0);
        rdv(`IAV_OFS_VECTORS, rd);
        chk(f ? rd[15:8] : rd[7:0], base);
        chk(f ? fifoIrq : usbIrq, 1'b0);
        wr(pd, 32'hffff_ffff);
    endtask : walk

    // Prints the counts and the verdict, then ends the run.
    task automatic wrapUp();
        $display("comparisons %0d, mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrapUp

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        logic [31:0] rd;
        logic er;
        logic [15:0] ent;
        logic [23:0] got;
        logic [2:0] seen;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        chk({usbIrq, fifoIrq}, 2'b00);
        rdv(`IAV_OFS_SETUP, rd);
        chk(rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0, rd, er);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        wr(`IAV_OFS_SETUP, 32'h3);
        walk(1'b0, `IAV_OFS_USB_IE, `IAV_OFS_USB_PEND, ~`IAV_USB_RSVD, 8'h00, 16'h0043, 8'h12);
        walk(1'b1, `IAV_OFS_FIFO_IE, `IAV_OFS_FIFO_PEND, 32'h3fff, 8'h80, 16'h0053, 8'h34);
        // With substitution off the memory bytes come through untouched.
        wr(`IAV_OFS_SETUP, 32'h0);
        core_u.serve(2'b01, ent, got, seen);
        chk(got, 24'h021277);
        core_u.serve(2'b10, ent, got, seen);
        chk(got, 24'h023499);
        // Both lines taken at once: only the USB entry is taken.
        core_u.serve(2'b11, ent, got, seen);
        chk(seen, 3'b111);
        chk(ent, 16'h0043);
        wrapUp();
    end

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge mclk);
        badCount++;
        wrapUp();
    end
endmodule : iav_autovector_tb

`default_nettype wire
